// >>> core/pcl_pkg.sv
// constants shared by the port pin configuration block
// assumes a 32-bit avalon-mm slave port and eight pins per port
package pcl_pkg;

  // port geometry
  localparam int PCL_NPORT = 11; // ports a b e k t s m p h j ad
  localparam int PCL_PIN_W = 8; // pins per port
  localparam int PCL_AW = 9; // byte address width of the slave
  localparam int PCL_DW = 32; // slave data width

  // port numbers, also the port field of the address (addr[8:5])
  localparam logic [3:0] PCL_PORT_A = 4'h0;
  localparam logic [3:0] PCL_PORT_B = 4'h1;
  localparam logic [3:0] PCL_PORT_E = 4'h2;
  localparam logic [3:0] PCL_PORT_K = 4'h3;
  localparam logic [3:0] PCL_PORT_T = 4'h4;
  localparam logic [3:0] PCL_PORT_S = 4'h5;
  localparam logic [3:0] PCL_PORT_M = 4'h6;
  localparam logic [3:0] PCL_PORT_P = 4'h7;
  localparam logic [3:0] PCL_PORT_H = 4'h8;
  localparam logic [3:0] PCL_PORT_J = 4'h9;
  localparam logic [3:0] PCL_PORT_AD = 4'ha;
  localparam logic [3:0] PCL_SHARED = 4'hb; // shared control page

  // per-port register slots, address field addr[4:2]
  localparam logic [2:0] PCL_F_DATA = 3'h0; // data / pin level
  localparam logic [2:0] PCL_F_DIR = 3'h1; // direction, 1 = output
  localparam logic [2:0] PCL_F_RDR = 3'h2; // drive_reduce_bit per pin
  localparam logic [2:0] PCL_F_PE = 3'h3; // pull_enable_bit per pin
  localparam logic [2:0] PCL_F_PS = 3'h4; // polarity_select_bit per pin
  localparam logic [2:0] PCL_F_OD = 3'h5; // open-drain select per pin
  localparam logic [2:0] PCL_F_IE = 3'h6; // pin_irq_enable_bit per pin
  localparam logic [2:0] PCL_F_FLAG = 3'h7; // pin interrupt flags, w1c

  // shared page slots
  localparam logic [2:0] PCL_S_PULLUP = 3'h0; // per-port pull-ups + debug
  localparam logic [2:0] PCL_S_REDUCE = 3'h1; // per-port reduced drive
  localparam logic [2:0] PCL_S_ROUTE = 3'h2; // peripheral routing
  localparam logic [2:0] PCL_S_STAT = 3'h3; // irq status, read clears
  localparam logic [2:0] PCL_S_MASK = 3'h4; // irq mask

  // capability sets, one bit per port number
  localparam logic [10:0] PCL_CAP_PE = 11'h7f0; // per-pin pull enable
  localparam logic [10:0] PCL_CAP_PS = 11'h3f0; // pull/edge polarity
  localparam logic [10:0] PCL_CAP_RDR = 11'h7f0; // per-pin reduced drive
  localparam logic [10:0] PCL_CAP_OD = 11'h060; // open-drain ports
  localparam logic [10:0] PCL_CAP_IRQ = 11'h380; // pin interrupt ports

  // field positions in the shared page
  localparam int PCL_PULLUP_DBG_BIT = 4; // background_debug_pin pull-up
  localparam int PCL_NIRQ = 3; // ports with pin interrupts
  localparam int PCL_IRQ_W = PCL_NIRQ * PCL_PIN_W; // status/mask width

  // reset values
  localparam logic [7:0] PCL_RST_BYTE = 8'h00;
  localparam logic [4:0] PCL_RST_PULLUP = 5'h00;
  localparam logic [3:0] PCL_RST_REDUCE = 4'h0;
  localparam logic [23:0] PCL_RST_MASK = 24'h000000;

  // glitch filter: a level must hold this long to be accepted
  localparam int PCL_CLK_NS = 4; // 250 mhz system clock
  localparam int PCL_FILT_NS = 20; // shortest accepted pulse
  localparam int PCL_FILT_CYC = (PCL_FILT_NS + PCL_CLK_NS - 1) / PCL_CLK_NS;
  localparam int PCL_FCW = 4; // filter counter width

endpackage : pcl_pkg

// >>> core/pcl_port_cfg.sv
// port pin configuration logic: pad control for eleven 8-pin ports
// assumes pads resolve level from pad_out/pad_oe_n and report pad_in
// synchronous to clk_sys_in; registers over avalon-mm with waitrequest
//
// What this block does
// RL1: direction 0 input, 1 drives data bit
// RL2: drive-reduce bit selects reduced drive on outputs
// RL3: input pull enabled; polarity 0 up, 1 down
// RL4: outputs never have a pull device active
// RL5: irq enable: polarity 0 falling, 1 rising
// RL6: ports a b e k ad polarity fixed 0
// RL7: pin interrupts only on ports p h j
// RL8: flags record pin interrupt events for software
// RL9: pin interrupt inputs glitch filtered before edges
// RL10: ports s m offer per-pin open-drain mode
// RL11: ports t s m p h j per-pin pull controls
// RL12: port ad per-pin pull-up enable only
// RL13: one register: per-port pull-ups plus debug pin
// RL14: a b e k reduce per port, others per pin
// RL15: register reads sampled synchronously to clock
// RL16: routing register relocates peripheral signals to pins
// RL17: drive-reduce ignored on input pins
// RL18: flag set on filtered edge, irq, w1c
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module pcl_port_cfg
  import pcl_pkg::*;
#(
  parameter int FILT_CYC = PCL_FILT_CYC // glitch filter length, cycles
) (
  input wire logic clk_sys_in, // 250 mhz system clock
  input wire logic rstn_in, // synchronous reset, active low
  input wire logic [PCL_AW-1:0] avs_address_in, // byte address
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [PCL_DW-1:0] avs_writedata_in, // write data
  input wire logic [3:0] avs_byteenable_in, // byte lanes
  output logic [PCL_DW-1:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // stall while register is fetched
  output logic irq_out, // level, unmasked flag pending
  input wire logic [PCL_NPORT*PCL_PIN_W-1:0] pad_in, // pad levels
  output logic [PCL_NPORT*PCL_PIN_W-1:0] pad_out, // pad drive level
  output logic [PCL_NPORT*PCL_PIN_W-1:0] pad_oe_n_out, // low = drive
  output logic [PCL_NPORT*PCL_PIN_W-1:0] pad_reduce_out, // weak drive
  output logic [PCL_NPORT*PCL_PIN_W-1:0] pad_pull_up_out, // pull-up on
  output logic [PCL_NPORT*PCL_PIN_W-1:0] pad_pull_dn_out, // pull-down on
  output logic background_debug_pin_pull_up_out, // pull-up on the debug pin
  input wire logic [PCL_PIN_W-1:0] periph_data_in, // peripheral drive
  input wire logic [PCL_PIN_W-1:0] periph_en_in, // peripheral owns pin
  output logic [PCL_PIN_W-1:0] periph_rx_out // routed pin level
);

  // elaboration checks
  // a longer filter would wrap the counter
  // and let pulses of any length through
  if (FILT_CYC < 1 || FILT_CYC > (2**PCL_FCW) - 1) begin : g_chk_filt
    $error("FILT_CYC out of range for the filter counter");
  end

  // bus handshake state
  // the slave answers after exactly one wait state
  logic ack_r; // second cycle of an access
  logic [PCL_DW-1:0] rdata_r; // captured read value
  logic [PCL_IRQ_W-1:0] stat_clr_r; // flags seen by a status read
  logic req; // any request present
  logic wr_en; // write commits this edge
  logic rd_en; // read completes this edge
  logic [3:0] a_port; // port field of address
  logic [2:0] a_fld; // slot field of address

  // shared control registers
  // the a b e k bits act on the whole port
  logic [4:0] pullup_r; // a b e k per port, bit 4 debug pin
  logic [3:0] reduce_r; // a b e k reduced drive per port
  logic [PCL_PIN_W-1:0] route_r; // 0 = port s, 1 = port m
  logic [PCL_IRQ_W-1:0] mask_r; // irq mask
  logic [PCL_IRQ_W-1:0] stat_w; // all pin interrupt flags

  // per-port register file
  // one byte per port and slot, by port number
  logic [7:0] data_r [PCL_NPORT]; // output data
  logic [7:0] dir_r [PCL_NPORT]; // direction
  logic [7:0] rdr_r [PCL_NPORT]; // per-pin reduced drive
  logic [7:0] pe_r [PCL_NPORT]; // per-pin pull enable
  logic [7:0] ps_r [PCL_NPORT]; // per-pin polarity
  logic [7:0] od_r [PCL_NPORT]; // per-pin open drain
  logic [7:0] ie_r [PCL_NPORT]; // per-pin irq enable
  logic [7:0] flag_r [PCL_NPORT]; // per-pin irq flags
  logic [7:0] rd_port [PCL_NPORT]; // read value of selected slot
  logic [PCL_DW-1:0] rd_val; // read mux output

  // reads and writes both commit in the second cycle
  assign req = avs_read_in | avs_write_in;
  assign wr_en = avs_write_in & ack_r;
  assign rd_en = avs_read_in & ack_r;
  assign a_port = avs_address_in[8:5];
  assign a_fld = avs_address_in[4:2];
  // one wait state on every access gives the read mux a full cycle
  assign avs_waitrequest_out = req & ~ack_r;
  assign avs_readdata_out = rdata_r;

  // access sequencer
  // ack_r is high one cycle per request; a request
  // left up after its answer starts a fresh access
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // read capture, clocked so reads see a stable sample
  // read-clear lands at the answer edge; an event at
  // the capture edge is not in stat_clr_r and survives
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rdata_r <= '0;
      stat_clr_r <= '0;
    end else if (req & ~ack_r) begin
      rdata_r <= avs_read_in ? rd_val : '0; // RL15
      // remember exactly what was reported so only those bits clear
      if (avs_read_in && a_port == PCL_SHARED && a_fld == PCL_S_STAT) begin
        stat_clr_r <= stat_w;
      end else begin
        stat_clr_r <= '0;
      end
    end
  end

  // read mux; unmapped addresses read zero
  // ports first, the shared page sits above them
  always_comb begin
    rd_val = '0;
    if (a_port < 4'(PCL_NPORT)) begin
      rd_val = {24'h000000, rd_port[a_port]};
    end else if (a_port == PCL_SHARED) begin
      unique case (a_fld)
        PCL_S_PULLUP: rd_val = {27'h0000000, pullup_r};
        PCL_S_REDUCE: rd_val = {28'h0000000, reduce_r};
        PCL_S_ROUTE: rd_val = {24'h000000, route_r};
        PCL_S_STAT: rd_val = {8'h00, stat_w};
        PCL_S_MASK: rd_val = {8'h00, mask_r};
        default: rd_val = '0; // slots 5..7 unmapped
      endcase
    end
  end

  // shared control page writes
  // these registers all fit in byte lane 0
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      pullup_r <= PCL_RST_PULLUP;
      reduce_r <= PCL_RST_REDUCE;
      route_r <= PCL_RST_BYTE;
    end else if (wr_en && a_port == PCL_SHARED && avs_byteenable_in[0]) begin
      unique case (a_fld)
        PCL_S_PULLUP: pullup_r <= avs_writedata_in[4:0]; // RL13
        PCL_S_REDUCE: reduce_r <= avs_writedata_in[3:0]; // RL14
        PCL_S_ROUTE: route_r <= avs_writedata_in[7:0]; // RL16
        default: ; // status and mask handled elsewhere
      endcase
    end
  end

  // irq mask, byte lanes honoured
  // lanes 0 1 2 cover ports p h j in that order
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      mask_r <= PCL_RST_MASK;
    end else if (wr_en && a_port == PCL_SHARED && a_fld == PCL_S_MASK) begin
      for (int l = 0; l < PCL_NIRQ; l++) begin
        if (avs_byteenable_in[l]) begin
          mask_r[l*8 +: 8] <= avs_writedata_in[l*8 +: 8];
        end
      end
    end
  end

  assign background_debug_pin_pull_up_out = pullup_r[PCL_PULLUP_DBG_BIT]; // RL13
  // combinational from flops, no added latency
  assign irq_out = |(stat_w & mask_r); // RL18

  // peripheral return path follows the routing choice
  // one cycle late; pad levels are already synchronous
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      periph_rx_out <= '0;
    end else begin
      for (int i = 0; i < PCL_PIN_W; i++) begin
        periph_rx_out[i] <= route_r[i] ? // RL16
          pad_in[32'(PCL_PORT_M)*PCL_PIN_W + i] :
          pad_in[32'(PCL_PORT_S)*PCL_PIN_W + i];
      end
    end
  end

  // per-port logic
  // every port gets its own slots and pad controls;
  // capability masks prune what a port lacks
  for (genvar g = 0; g < PCL_NPORT; g++) begin : g_port
    logic sel; // byte-0 write to this port
    logic [7:0] pad; // this port's pad levels
    logic [7:0] pe_eff; // pull enable after port rules
    logic [7:0] ps_eff; // polarity after port rules
    logic [7:0] rdr_eff; // reduced drive after port rules
    logic [7:0] od_eff; // open drain after port rules
    logic [7:0] ovr; // pins taken by a routed peripheral
    logic [7:0] drv_dir; // effective direction
    logic [7:0] drv_dat; // effective output level
    logic [7:0] filt_set; // new flag events

    assign sel = wr_en & (a_port == 4'(g)) & avs_byteenable_in[0];
    assign pad = pad_in[g*PCL_PIN_W +: PCL_PIN_W];

    // configuration writes; slots a port lacks stay at reset
    // so software reads a missing slot back as zero
    always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
        data_r[g] <= PCL_RST_BYTE;
        dir_r[g] <= PCL_RST_BYTE;
        rdr_r[g] <= PCL_RST_BYTE;
        pe_r[g] <= PCL_RST_BYTE;
        ps_r[g] <= PCL_RST_BYTE;
        od_r[g] <= PCL_RST_BYTE;
        ie_r[g] <= PCL_RST_BYTE;
      end else if (sel) begin
        unique case (a_fld)
          PCL_F_DATA: data_r[g] <= avs_writedata_in[7:0];
          PCL_F_DIR: dir_r[g] <= avs_writedata_in[7:0];
          PCL_F_RDR: if (PCL_CAP_RDR[g]) rdr_r[g] <= avs_writedata_in[7:0];
          PCL_F_PE: if (PCL_CAP_PE[g]) pe_r[g] <= avs_writedata_in[7:0];
          PCL_F_PS: if (PCL_CAP_PS[g]) ps_r[g] <= avs_writedata_in[7:0];
          PCL_F_OD: if (PCL_CAP_OD[g]) od_r[g] <= avs_writedata_in[7:0];
          PCL_F_IE: if (PCL_CAP_IRQ[g]) ie_r[g] <= avs_writedata_in[7:0];
          PCL_F_FLAG: ; // write-one-clear, handled with the flags
        endcase
      end
    end

    // per-port versus per-pin controls
    // a b e k take pulls and reduce from shared page
    if (PCL_CAP_PE[g]) begin : g_pin_pull
      assign pe_eff = pe_r[g]; // RL11 RL12
    end else begin : g_port_pull
      assign pe_eff = {8{pullup_r[g]}}; // RL13
    end
    if (PCL_CAP_RDR[g]) begin : g_pin_rdr
      assign rdr_eff = rdr_r[g]; // RL14
    end else begin : g_port_rdr
      assign rdr_eff = {8{reduce_r[g]}}; // RL14
    end
    // ports without polarity control always pull up
    assign ps_eff = PCL_CAP_PS[g] ? ps_r[g] : 8'h00; // RL6 RL12
    assign od_eff = PCL_CAP_OD[g] ? od_r[g] : 8'h00; // RL10

    // routed peripherals take over the pins of port s or port m
    // a routed pin is forced to output; open drain
    // and reduce settings of that pin still apply
    if (g == PCL_PORT_S) begin : g_route_s
      assign ovr = periph_en_in & ~route_r; // RL16
    end else if (g == PCL_PORT_M) begin : g_route_m
      assign ovr = periph_en_in & route_r; // RL16
    end else begin : g_route_none
      assign ovr = 8'h00;
    end
    assign drv_dir = dir_r[g] | ovr; // RL1
    assign drv_dat = (ovr & periph_data_in) | (~ovr & data_r[g]); // RL1

    // pad controls, registered so the pads see clean levels
    // they follow a committed write by one edge
    always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
        pad_out[g*PCL_PIN_W +: PCL_PIN_W] <= 8'h00;
        pad_oe_n_out[g*PCL_PIN_W +: PCL_PIN_W] <= 8'hff;
        pad_reduce_out[g*PCL_PIN_W +: PCL_PIN_W] <= 8'h00;
        pad_pull_up_out[g*PCL_PIN_W +: PCL_PIN_W] <= 8'h00;
        pad_pull_dn_out[g*PCL_PIN_W +: PCL_PIN_W] <= 8'h00;
      end else begin
        pad_out[g*PCL_PIN_W +: PCL_PIN_W] <= drv_dat; // RL1
        // open drain only pulls low; a high level releases the pin
        pad_oe_n_out[g*PCL_PIN_W +: PCL_PIN_W] <=
          ~(drv_dir & ~(od_eff & drv_dat)); // RL1 RL10
        // reduced drive is meaningless on inputs, so gate it off
        pad_reduce_out[g*PCL_PIN_W +: PCL_PIN_W] <=
          rdr_eff & drv_dir; // RL2 RL17
        pad_pull_up_out[g*PCL_PIN_W +: PCL_PIN_W] <=
          pe_eff & ~drv_dir & ~ps_eff; // RL3 RL4
        pad_pull_dn_out[g*PCL_PIN_W +: PCL_PIN_W] <=
          pe_eff & ~drv_dir & ps_eff; // RL3 RL4
      end
    end

    // pin interrupt path, present only where the port supports it
    // filter flops exist on p h j only, saving
    // them on the eight ports without interrupts
    if (PCL_CAP_IRQ[g]) begin : g_irq
      for (genvar b = 0; b < PCL_PIN_W; b++) begin : g_bit
        logic [PCL_FCW-1:0] cnt_r; // cycles the new level has held
        logic filt_r; // accepted level
        logic prev_r; // accepted level one cycle earlier

        // level must hold FILT_CYC cycles; shorter pulses vanish
        // a pin high at reset yields one accepted rise;
        // harmless, the enable bits are still clear
        always_ff @(posedge clk_sys_in) begin
          if (!rstn_in) begin
            cnt_r <= '0;
            filt_r <= 1'b0;
            prev_r <= 1'b0;
          end else begin
            prev_r <= filt_r;
            if (pad[b] == filt_r) begin
              cnt_r <= '0;
            end else if (cnt_r == PCL_FCW'(FILT_CYC - 1)) begin
              filt_r <= pad[b]; // RL9
              cnt_r <= '0;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
        end

        // edge select works whatever the pin direction
        // polarity 1 picks rising, 0 picks falling
        assign filt_set[b] = ie_r[g][b] & (ps_eff[b] ? // RL5 RL7
          (filt_r & ~prev_r) : (~filt_r & prev_r));
      end

      // sticky flags; a new event beats a clear in the same cycle
      // so a clear racing an edge never loses it;
      // w1c and read-clear are treated alike
      always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          flag_r[g] <= PCL_RST_BYTE;
        end else begin
          flag_r[g] <= (flag_r[g] & ~((sel && a_fld == PCL_F_FLAG) ?
            avs_writedata_in[7:0] : 8'h00)
            & ~(rd_en ? stat_clr_r[(g-PCL_PORT_P)*8 +: 8] : 8'h00))
            | filt_set; // RL8 RL18
        end
      end
      assign stat_w[(g-PCL_PORT_P)*8 +: 8] = flag_r[g]; // RL8
    end else begin : g_no_irq
      // no interrupt: flags and events stay zero
      assign filt_set = 8'h00; // RL7
      always_ff @(posedge clk_sys_in) begin
        flag_r[g] <= PCL_RST_BYTE; // RL7
      end
    end

    // register read for this port; inputs read the pad level
    // outputs read back their data latch
    always_comb begin
      unique case (a_fld)
        PCL_F_DATA: rd_port[g] = (dir_r[g] & data_r[g]) | (~dir_r[g] & pad);
        PCL_F_DIR: rd_port[g] = dir_r[g];
        PCL_F_RDR: rd_port[g] = rdr_r[g];
        PCL_F_PE: rd_port[g] = pe_r[g];
        PCL_F_PS: rd_port[g] = ps_r[g];
        PCL_F_OD: rd_port[g] = od_r[g];
        PCL_F_IE: rd_port[g] = ie_r[g];
        PCL_F_FLAG: rd_port[g] = flag_r[g];
      endcase
    end
  end

endmodule // pcl_port_cfg

`default_nettype wire

// >>> verification/pcl_board.sv
// board model: resolves each pad from chip drive, pulls and bench drive
// assumes the bench drives ext_* only where it plays an outside driver
`timescale 1ns/100ps
`default_nettype none
module pcl_board
  import pcl_pkg::*;
(
  input wire logic clk_sys_in, // clock for the float pattern
  input wire logic [PCL_NPORT*PCL_PIN_W-1:0] drv_in, // chip drive level
  input wire logic [PCL_NPORT*PCL_PIN_W-1:0] oe_n_in, // low = chip drives
  input wire logic [PCL_NPORT*PCL_PIN_W-1:0] pu_in, // pull-up on
  input wire logic [PCL_NPORT*PCL_PIN_W-1:0] pd_in, // pull-down on
  input wire logic [PCL_NPORT*PCL_PIN_W-1:0] ext_en_in, // bench drives
  input wire logic [PCL_NPORT*PCL_PIN_W-1:0] ext_val_in, // bench level
  output logic [PCL_NPORT*PCL_PIN_W-1:0] level_out // resolved level
);
  // last level, so a floating pin never repeats it
  logic [PCL_NPORT*PCL_PIN_W-1:0] last_r = '0;
  always @(posedge clk_sys_in) last_r <= level_out;
  // outside driver wins, then chip, then pulls, else float
  always_comb begin
    for (int i = 0; i < PCL_NPORT*PCL_PIN_W; i++) begin
      if (ext_en_in[i]) level_out[i] = ext_val_in[i];
      else if (!oe_n_in[i]) level_out[i] = drv_in[i];
      else if (pu_in[i]) level_out[i] = 1'b1;
      else if (pd_in[i]) level_out[i] = 1'b0;
      else level_out[i] = ~last_r[i];
    end
  end
endmodule // pcl_board
`default_nettype wire

// >>> verification/pcl_port_cfg_sva.sv
// checker for the port pin configuration block
// assumes it is bound onto pcl_port_cfg, one clock domain
`timescale 1ns/100ps
`default_nettype none
module pcl_port_cfg_chk
  import pcl_pkg::*;
(
  input wire logic clk_sys_in, // system clock
  input wire logic rstn_in, // reset, active low
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [PCL_DW-1:0] avs_readdata_out, // read data
  input wire logic avs_waitrequest_out, // stall
  input wire logic [PCL_NPORT*PCL_PIN_W-1:0] pad_oe_n_out, // low = drive
  input wire logic [PCL_NPORT*PCL_PIN_W-1:0] pad_reduce_out, // weak
  input wire logic [PCL_NPORT*PCL_PIN_W-1:0] pad_pull_up_out, // pull-up
  input wire logic [PCL_NPORT*PCL_PIN_W-1:0] pad_pull_dn_out, // pull-down
  input wire logic [PCL_NPORT*PCL_PIN_W-1:0] pad_out // drive level
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // any request in flight
  logic req;
  assign req = avs_read_in || avs_write_in;
  property p_wait_first; $rose(req) |-> avs_waitrequest_out; endproperty
  a_wait_first: assert property (p_wait_first)
    else $error("no wait state on new request");
  property p_one_wait; req && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("more than one wait state");
  property p_wait_req; avs_waitrequest_out |-> req; endproperty
  a_wait_req: assert property (p_wait_req)
    else $error("waitrequest without request");
  // read data must not drift between requests
  property p_rd_hold; !req |=> $stable(avs_readdata_out); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed while idle");
  property p_reset_input; $rose(rstn_in) |-> &pad_oe_n_out; endproperty
  a_reset_input: assert property (p_reset_input)
    else $error("pin driven straight after reset");
  property p_no_pull_out;
    ((~pad_oe_n_out) & (pad_pull_up_out | pad_pull_dn_out)) == '0;
  endproperty
  a_no_pull_out: assert property (p_no_pull_out)
    else $error("pull active on driven pin");
  property p_pull_excl; (pad_pull_up_out & pad_pull_dn_out) == '0; endproperty
  a_pull_excl: assert property (p_pull_excl)
    else $error("pull-up and pull-down together");
  // released open-drain pins on s and m may keep reduce set
  property p_reduce_out;
    (pad_reduce_out & pad_oe_n_out & ~(pad_out & {32'h0, 16'hffff, 40'h0}))
      == '0;
  endproperty
  a_reduce_out: assert property (p_reduce_out)
    else $error("reduced drive on undriven pin");
  // a b e k and ad only ever pull up
  property p_fixed_up;
    pad_pull_dn_out[31:0] == 32'h0 && pad_pull_dn_out[87:80] == 8'h00;
  endproperty
  a_fixed_up: assert property (p_fixed_up)
    else $error("pull-down on fixed polarity port");
endmodule // pcl_port_cfg_chk

bind pcl_port_cfg pcl_port_cfg_chk u_chk (.clk_sys_in(clk_sys_in),
  .rstn_in(rstn_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .pad_oe_n_out(pad_oe_n_out),
  .pad_reduce_out(pad_reduce_out), .pad_pull_up_out(pad_pull_up_out),
  .pad_pull_dn_out(pad_pull_dn_out), .pad_out(pad_out));
`default_nettype wire

// >>> verification/pcl_port_cfg_tb.sv
// self-checking bench for the port pin configuration block
// assumes the board model on the pads and avalon-mm register access
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module pcl_port_cfg_tb;
  import pcl_pkg::*;
  localparam int W = PCL_NPORT * PCL_PIN_W; // all pads
  logic clk = 1'b0; // 250 mhz
  logic rstn = 1'b0; // reset, active low
  logic rd = 1'b0, wr = 1'b0; // bus strobes
  logic [8:0] addr = '0; // byte address
  logic [31:0] wd = '0, rdata, q; // bus data
  logic wreq, irq, background_debug_pin; // dut flags
  logic [W-1:0] lvl, p_out, p_oen, p_red, p_pu, p_pd; // pad nets
  logic [W-1:0] ext_en = {24'h0, 8'hff, 56'h0}; // bench owns port p
  logic [W-1:0] ext_val = {24'h0, 8'h01, 56'h0}; // p0 high, p1 low
  logic [7:0] pdat = '0, pen = '0, prx; // routed peripheral
  int error_cnt = 0, compares = 0;
  initial forever #2 clk = ~clk;
  // short filter keeps the edge tests brief
  pcl_port_cfg #(.FILT_CYC(2)) dut (.clk_sys_in(clk), .rstn_in(rstn),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .irq_out(irq),
    .pad_in(lvl), .pad_out(p_out), .pad_oe_n_out(p_oen),
    .pad_reduce_out(p_red), .pad_pull_up_out(p_pu),
    .pad_pull_dn_out(p_pd), .background_debug_pin_pull_up_out(background_debug_pin),
    .periph_data_in(pdat), .periph_en_in(pen), .periph_rx_out(prx));
  pcl_board u_board (.clk_sys_in(clk), .drv_in(p_out), .oe_n_in(p_oen),
    .pu_in(p_pu), .pd_in(p_pd), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .level_out(lvl));
  // verdict and end of run
  task stop_test;
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one bus cycle; request held until waitrequest is low at an edge,
  // a slave that never answers is left to the hang guard
  task bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wd <= d; rd <= !w; wr <= w;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    q = rdata; // taken at the answer edge
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task wrr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rchk(input logic [8:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    `CHK(q, e)
  endtask
  // pads follow one edge after commit
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  function logic [8:0] ra(input logic [3:0] p, input logic [2:0] s);
    return {p, s, 2'b00};
  endfunction
  function logic [7:0] pb(input logic [W-1:0] v, input int p);
    return v[8*p +: 8];
  endfunction
  // hang guard at 25000 cycles, far beyond the couple of hundred cycles needed
  initial begin
    #100000;
    error_cnt++;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (12) @(posedge clk);
    #1 `CHK(p_oen, {W{1'b1}})
    rchk(ra(PCL_PORT_T, PCL_F_DIR), 32'h0);
    // port t: mixed directions, drive and pulls
    wrr(ra(PCL_PORT_T, PCL_F_DATA), 32'ha5);
    wrr(ra(PCL_PORT_T, PCL_F_DIR), 32'h0f);
    wrr(ra(PCL_PORT_T, PCL_F_RDR), 32'h33);
    wrr(ra(PCL_PORT_T, PCL_F_PE), 32'hff);
    wrr(ra(PCL_PORT_T, PCL_F_PS), 32'hcc);
    settle;
    `CHK(pb(p_oen, 4), 8'hf0)
    `CHK(pb(p_out, 4) & 8'h0f, 8'h05)
    `CHK(pb(p_red, 4), 8'h03)
    `CHK(pb(p_pu, 4), 8'h30)
    `CHK(pb(p_pd, 4), 8'hc0)
    rchk(ra(PCL_PORT_T, PCL_F_RDR), 32'h33);
    // port ad: polarity write has no effect
    wrr(ra(PCL_PORT_AD, PCL_F_PE), 32'hff);
    wrr(ra(PCL_PORT_AD, PCL_F_PS), 32'hff);
    settle;
    `CHK(pb(p_pu, 10), 8'hff)
    `CHK(pb(p_pd, 10), 8'h00)
    rchk(ra(PCL_PORT_AD, PCL_F_PS), 32'h0);
    // whole-port pull-up and reduce controls
    wrr(ra(PCL_SHARED, PCL_S_PULLUP), 32'h1f);
    wrr(ra(PCL_SHARED, PCL_S_REDUCE), 32'h02);
    wrr(ra(PCL_PORT_B, PCL_F_DIR), 32'hff);
    wrr(ra(PCL_PORT_E, PCL_F_DIR), 32'hff);
    settle;
    `CHK(background_debug_pin, 1'b1)
    `CHK(pb(p_pu, 0), 8'hff)
    `CHK(pb(p_pu, 1), 8'h00)
    `CHK(pb(p_red, 1), 8'hff)
    `CHK(pb(p_red, 2), 8'h00)
    // port s open drain: ones are released, zeros driven low
    wrr(ra(PCL_PORT_S, PCL_F_DATA), 32'h0f);
    wrr(ra(PCL_PORT_S, PCL_F_DIR), 32'hff);
    wrr(ra(PCL_PORT_S, PCL_F_OD), 32'hff);
    settle;
    `CHK(pb(p_oen, 5), 8'h0f)
    `CHK(pb(p_out, 5) & ~pb(p_oen, 5), 8'h00)
    // peripheral 1 moved to port m pin 1
    wrr(ra(PCL_SHARED, PCL_S_ROUTE), 32'h02);
    @(posedge clk);
    pdat <= 8'h02; pen <= 8'h02;
    settle;
    settle;
    `CHK(pb(p_oen, 6) & 8'h02, 8'h00)
    `CHK(pb(p_out, 6) & 8'h02, 8'h02)
    `CHK(prx & 8'h02, 8'h02)
    // pin interrupts: refused port, unmapped place, filter, flags
    wrr(ra(PCL_PORT_T, PCL_F_IE), 32'hff);
    rchk(ra(PCL_PORT_T, PCL_F_IE), 32'h0);
    rchk(9'h1fc, 32'h0);
    wrr(ra(PCL_PORT_P, PCL_F_IE), 32'h03);
    wrr(ra(PCL_PORT_P, PCL_F_PS), 32'h02);
    @(posedge clk) ext_val[56] <= 1'b0;
    @(posedge clk) ext_val[56] <= 1'b1;
    repeat (10) @(posedge clk);
    rchk(ra(PCL_PORT_P, PCL_F_FLAG), 32'h0);
    @(posedge clk);
    ext_val[56] <= 1'b0; ext_val[57] <= 1'b1;
    repeat (10) @(posedge clk);
    #1 `CHK(irq, 1'b0)
    rchk(ra(PCL_PORT_P, PCL_F_FLAG), 32'h03);
    wrr(ra(PCL_SHARED, PCL_S_MASK), 32'h03);
    settle;
    `CHK(irq, 1'b1)
    rchk(ra(PCL_SHARED, PCL_S_STAT), 32'h03);
    #1 `CHK(irq, 1'b0)
    rchk(ra(PCL_SHARED, PCL_S_STAT), 32'h0);
    // wrong-way edges set nothing; then both flags again
    ext_val[56] <= 1'b1;
    ext_val[57] <= 1'b0;
    repeat (10) @(posedge clk);
    rchk(ra(PCL_PORT_P, PCL_F_FLAG), 32'h0);
    ext_val[56] <= 1'b0;
    ext_val[57] <= 1'b1;
    repeat (10) @(posedge clk);
    wrr(ra(PCL_PORT_P, PCL_F_FLAG), 32'h01);
    rchk(ra(PCL_PORT_P, PCL_F_FLAG), 32'h02);
    stop_test;
  end
endmodule // pcl_port_cfg_tb
`default_nettype wire
